//--- include/srac_defines.svh
// Operation
// - Two carrier frequency words A and B, one hertz per step.
// - Setting ranging_go in either ranging register starts auto-ranging.
// - ranging_go reads back and clears to 0 when ranging completes.
// - Register A ranges frequency A; register B ranges frequency B.
// - ranging_fault reports whether the latest ranging run went correctly.
// - Ranging works with internal VCO or external inductor, not external VCO.
// - On synth start, boost filter and pump apply for programmed time.
// - Two-bit loop_filter_sel; 00 bypasses filter and drives external pin.
// - Filter settings give bandwidth steps of two and five times base.
// - Eight-bit pump_current held in normal and boost registers.
// - inductor_sel 0 with osc_source_sel 1 selects fully external VCO.
// - Divider register also holds ref_divider_field.
// - Differential mode switches internally; single-ended leaves it external.
// - One pin drives TX/RX switch, another drives antenna select.
// - Diversity probes both antennas when idle, picks stronger automatically.
// - Optionally diversity writes both RSSI values into receive FIFO.
// - Switch pin drives only with alternate and direction bits set.
`ifndef SRAC_DEFINES_SVH
`define SRAC_DEFINES_SVH

`define SRAC_CLK_PERIOD_NS 25
`define SRAC_SETTLE_NS 50000
`define SRAC_SETTLE_CYC ((`SRAC_SETTLE_NS + `SRAC_CLK_PERIOD_NS - 1) / `SRAC_CLK_PERIOD_NS)

`define SRAC_OFS_FREQ_A 8'h00
`define SRAC_OFS_FREQ_B 8'h04
`define SRAC_OFS_RANGING_A 8'h08
`define SRAC_OFS_RANGING_B 8'h0C
`define SRAC_OFS_LOOP 8'h10
`define SRAC_OFS_LOOP_BOOST 8'h14
`define SRAC_OFS_PUMP 8'h18
`define SRAC_OFS_PUMP_BOOST 8'h1C
`define SRAC_OFS_VCO_DIV 8'h20
`define SRAC_OFS_BOOST_CFG 8'h24
`define SRAC_OFS_ANT_CFG 8'h28
`define SRAC_OFS_ALT_FUNC 8'h2C
`define SRAC_OFS_DIR_B 8'h30
`define SRAC_OFS_STATUS 8'h34

`define SRAC_RNG_GO_BIT 4
`define SRAC_RNG_FAULT_BIT 5
`define SRAC_DIV_OUT_BIT 2
`define SRAC_DIV_OSC_BIT 4
`define SRAC_DIV_IND_BIT 5
`define SRAC_BOOST_EN_BIT 16
`define SRAC_ANT_DIFF_BIT 0
`define SRAC_ANT_DIV_BIT 1
`define SRAC_ANT_LOG_BIT 2
`define SRAC_ALT_SWITCH_BIT 6
`define SRAC_ALT_ANTSEL_BIT 7
`define SRAC_DIR_SWITCH_BIT 2
`define SRAC_DIR_ANTSEL_BIT 3

`define SRAC_RST_LOOP 2'h1
`define SRAC_RST_PUMP 8'h10
`define SRAC_RST_ANT_CFG 32'h0000_1001
`define SRAC_RST_BOOST_CFG 32'h0000_0000

`define SRAC_RESP_OKAY 2'h0
`define SRAC_RESP_SLVERR 2'h2

`endif

//--- include/srac_pkg.sv
package srac_pkg;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } srac_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } srac_axi_rsp_s;

    typedef struct packed {
        logic [1:0] loop_filter_sel;
        logic [7:0] pump_current;
    } srac_loop_s;

    typedef enum logic [1:0] {
        SRAC_RNG_IDLE,
        SRAC_RNG_SETTLE,
        SRAC_RNG_DONE
    } srac_rng_state_e;

    typedef enum logic [2:0] {
        SRAC_DIV_WAIT,
        SRAC_DIV_DWELL_0,
        SRAC_DIV_DWELL_1,
        SRAC_DIV_PICK,
        SRAC_DIV_LOG
    } srac_div_state_e;

endpackage

//--- verilog/srac_ranging.sv
`timescale 1ns/1ps
`include "srac_defines.svh"

module srac_ranging
    import srac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic use_b,
    input wire logic ext_vco,
    input wire logic [31:0] freq_a,
    input wire logic [31:0] freq_b,
    // Comparator, already synchronised
    input wire logic vco_high,
    // Results
    output logic busy,
    output logic done,
    output logic fault,
    output logic [3:0] range_val,
    output logic [31:0] freq_out
);

    srac_rng_state_e state;
    logic [1:0] bit_idx;
    logic [11:0] settle;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SRAC_RNG_IDLE;
            bit_idx <= 2'h3;
            settle <= 12'h000;
            range_val <= 4'h8;
            busy <= 1'b0;
            done <= 1'b0;
            fault <= 1'b0;
            freq_out <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            case (state)
                SRAC_RNG_IDLE: begin
                    if (start) begin
                        freq_out <= use_b ? freq_b : freq_a;
                        busy <= 1'b1;
                        if (ext_vco) begin
                            state <= SRAC_RNG_DONE;
                        end else begin
                            range_val <= 4'h8;
                            bit_idx <= 2'h3;
                            settle <= 12'(`SRAC_SETTLE_CYC - 1);
                            state <= SRAC_RNG_SETTLE;
                        end
                    end
                end
                SRAC_RNG_SETTLE: begin
                    if (settle != 12'h000) begin
                        settle <= settle - 12'h001;
                    end else begin
                        // Binary search: too high clears the trial bit
                        if (vco_high) begin
                            range_val[bit_idx] <= 1'b0;
                        end
                        if (bit_idx == 2'h0) begin
                            state <= SRAC_RNG_DONE;
                        end else begin
                            range_val[bit_idx - 2'h1] <= 1'b1;
                            bit_idx <= bit_idx - 2'h1;
                            settle <= 12'(`SRAC_SETTLE_CYC - 1);
                        end
                    end
                end
                SRAC_RNG_DONE: begin
                    // End stop means the band was not bracketed
                    fault <= ext_vco || range_val == 4'h0 || range_val == 4'hF;
                    done <= 1'b1;
                    busy <= 1'b0;
                    state <= SRAC_RNG_IDLE;
                end
                default: begin
                    state <= SRAC_RNG_IDLE;
                end
            endcase
        end
    end

endmodule

//--- verilog/srac_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "srac_defines.svh"

module srac_top
    import srac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire srac_axi_req_s axi_req,
    output srac_axi_rsp_s axi_rsp,
    // Radio controller, same clock
    input wire logic synth_on,
    input wire logic tx_active,
    input wire logic rx_packet_busy,
    input wire logic [7:0] rssi,
    // Analog comparator, asynchronous
    input wire logic vco_high_async,
    // Synthesizer control
    output logic [31:0] synth_freq,
    output logic [3:0] vco_range,
    output srac_loop_s loop_active,
    output logic loop_voltage_pin_en,
    output logic [1:0] ref_divider_field,
    output logic output_divider_bit,
    output logic osc_source_sel,
    output logic inductor_sel,
    output logic boost_active,
    // Antenna control
    output logic internal_switch_tx,
    output logic single_ended_tx_pin_en,
    output logic txrx_switch_pin_o,
    output logic txrx_switch_pin_oe,
    output logic antenna_select_pin_o,
    output logic antenna_select_pin_oe,
    // Receive FIFO write
    output logic rssi_fifo_wr,
    output logic [9:0] rssi_fifo_data
);

    logic [31:0] freq_a, freq_b, boost_cfg, ant_cfg;
    logic [1:0] loop_norm, loop_boost;
    logic [7:0] pump_norm, pump_boost, radio_alt_function_reg, port_b_direction;
    logic [5:0] vco_div;
    logic go_a, go_b, ranging_fault, rng_owner_b;
    logic vco_meta, vco_high;
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic ranging_go, rng_busy, rng_done, rng_fault;
    logic [3:0] rng_range;
    logic [31:0] rng_freq;
    logic synth_on_d;
    logic [15:0] boost_cnt;
    srac_div_state_e div_state;
    logic [15:0] div_timer;
    logic [7:0] rssi_ant0, rssi_ant1;
    logic antenna;
    logic wr_fire;
    logic [31:0] rd_word;
    logic rd_ok;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // Comparator synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            vco_meta <= 1'b0;
            vco_high <= 1'b0;
        end else begin
            vco_meta <= vco_high_async;
            vco_high <= vco_meta;
        end
    end

    // AXI write address and data, taken in either order
    assign wr_fire = aw_got && w_got && !axi_rsp.bvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            axi_rsp.awready <= 1'b1;
            axi_rsp.wready <= 1'b1;
            axi_rsp.bvalid <= 1'b0;
            axi_rsp.bresp <= `SRAC_RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (axi_req.awvalid && axi_rsp.awready) begin
                aw_addr <= axi_req.awaddr;
                aw_got <= 1'b1;
                axi_rsp.awready <= 1'b0;
            end
            if (axi_req.wvalid && axi_rsp.wready) begin
                w_data <= axi_req.wdata;
                w_strb <= axi_req.wstrb;
                w_got <= 1'b1;
                axi_rsp.wready <= 1'b0;
            end
            if (wr_fire) begin
                axi_rsp.bvalid <= 1'b1;
                axi_rsp.bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= `SRAC_OFS_DIR_B)
                    ? `SRAC_RESP_OKAY : `SRAC_RESP_SLVERR;
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
            if (axi_rsp.bvalid && axi_req.bready) begin
                axi_rsp.bvalid <= 1'b0;
                axi_rsp.awready <= 1'b1;
                axi_rsp.wready <= 1'b1;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            freq_a <= 32'h0000_0000;
            freq_b <= 32'h0000_0000;
            loop_norm <= `SRAC_RST_LOOP;
            loop_boost <= `SRAC_RST_LOOP;
            pump_norm <= `SRAC_RST_PUMP;
            pump_boost <= `SRAC_RST_PUMP;
            vco_div <= 6'h00;
            boost_cfg <= `SRAC_RST_BOOST_CFG;
            ant_cfg <= `SRAC_RST_ANT_CFG;
            radio_alt_function_reg <= 8'h00;
            port_b_direction <= 8'h00;
        end else if (wr_fire) begin
            case (aw_addr)
                `SRAC_OFS_FREQ_A: freq_a <= merge(freq_a, w_data, w_strb);
                `SRAC_OFS_FREQ_B: freq_b <= merge(freq_b, w_data, w_strb);
                `SRAC_OFS_LOOP: if (w_strb[0]) loop_norm <= w_data[1:0];
                `SRAC_OFS_LOOP_BOOST: if (w_strb[0]) loop_boost <= w_data[1:0];
                `SRAC_OFS_PUMP: if (w_strb[0]) pump_norm <= w_data[7:0];
                `SRAC_OFS_PUMP_BOOST: if (w_strb[0]) pump_boost <= w_data[7:0];
                `SRAC_OFS_VCO_DIV: if (w_strb[0]) vco_div <= w_data[5:0];
                `SRAC_OFS_BOOST_CFG: boost_cfg <= merge(boost_cfg, w_data, w_strb);
                `SRAC_OFS_ANT_CFG: ant_cfg <= merge(ant_cfg, w_data, w_strb);
                `SRAC_OFS_ALT_FUNC: if (w_strb[0]) radio_alt_function_reg <= w_data[7:0];
                `SRAC_OFS_DIR_B: if (w_strb[0]) port_b_direction <= w_data[7:0];
                default: begin
                end
            endcase
        end
    end

    // Ranging go bits: start only when idle, cleared with the result
    always_ff @(posedge clk) begin
        if (rst) begin
            go_a <= 1'b0;
            go_b <= 1'b0;
            rng_owner_b <= 1'b0;
            ranging_go <= 1'b0;
            ranging_fault <= 1'b0;
        end else begin
            ranging_go <= 1'b0;
            if (rng_done) begin
                go_a <= 1'b0;
                go_b <= 1'b0;
                ranging_fault <= rng_fault;
            end else if (wr_fire && w_strb[0] && w_data[`SRAC_RNG_GO_BIT] && !go_a && !go_b
                         && (aw_addr == `SRAC_OFS_RANGING_A
                             || aw_addr == `SRAC_OFS_RANGING_B)) begin
                go_a <= aw_addr == `SRAC_OFS_RANGING_A;
                go_b <= aw_addr == `SRAC_OFS_RANGING_B;
                rng_owner_b <= aw_addr == `SRAC_OFS_RANGING_B;
                ranging_go <= 1'b1;
            end
        end
    end

    srac_ranging u_ranging (
        .clk(clk),
        .rst(rst),
        .start(ranging_go),
        .use_b(rng_owner_b),
        .ext_vco(vco_div[`SRAC_DIV_OSC_BIT] && !vco_div[`SRAC_DIV_IND_BIT]),
        .freq_a(freq_a),
        .freq_b(freq_b),
        .vco_high(vco_high),
        .busy(rng_busy),
        .done(rng_done),
        .fault(rng_fault),
        .range_val(rng_range),
        .freq_out(rng_freq)
    );

    // Boost window counted in clocks; each new start reloads it
    always_ff @(posedge clk) begin
        if (rst) begin
            synth_on_d <= 1'b0;
            boost_cnt <= 16'h0000;
        end else begin
            synth_on_d <= synth_on;
            if (!synth_on) begin
                boost_cnt <= 16'h0000;
            end else if (!synth_on_d && boost_cfg[`SRAC_BOOST_EN_BIT]) begin
                boost_cnt <= boost_cfg[15:0];
            end else if (boost_cnt != 16'h0000) begin
                boost_cnt <= boost_cnt - 16'h0001;
            end
        end
    end

    // Synthesizer outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            synth_freq <= 32'h0000_0000;
            vco_range <= 4'h8;
            loop_active <= '0;
            loop_voltage_pin_en <= 1'b0;
            ref_divider_field <= 2'h0;
            output_divider_bit <= 1'b0;
            osc_source_sel <= 1'b0;
            inductor_sel <= 1'b0;
            boost_active <= 1'b0;
        end else begin
            synth_freq <= rng_busy ? rng_freq : (rng_owner_b ? freq_b : freq_a);
            vco_range <= rng_range;
            boost_active <= boost_cnt != 16'h0000;
            if (boost_cnt != 16'h0000) begin
                loop_active.loop_filter_sel <= loop_boost;
                loop_active.pump_current <= pump_boost;
                loop_voltage_pin_en <= loop_boost == 2'h0;
            end else begin
                loop_active.loop_filter_sel <= loop_norm;
                loop_active.pump_current <= pump_norm;
                loop_voltage_pin_en <= loop_norm == 2'h0;
            end
            ref_divider_field <= vco_div[1:0];
            output_divider_bit <= vco_div[`SRAC_DIV_OUT_BIT];
            osc_source_sel <= vco_div[`SRAC_DIV_OSC_BIT];
            inductor_sel <= vco_div[`SRAC_DIV_IND_BIT];
        end
    end

    // Antenna diversity: probe both when no packet is in progress
    always_ff @(posedge clk) begin
        if (rst) begin
            div_state <= SRAC_DIV_WAIT;
            div_timer <= 16'h0000;
            rssi_ant0 <= 8'h00;
            rssi_ant1 <= 8'h00;
            antenna <= 1'b0;
            rssi_fifo_wr <= 1'b0;
            rssi_fifo_data <= 10'h000;
        end else begin
            // Second word of a logged pair follows even if probing stops
            rssi_fifo_wr <= div_state == SRAC_DIV_LOG;
            rssi_fifo_data <= {2'h1, rssi_ant1};
            if (!ant_cfg[`SRAC_ANT_DIV_BIT] || rx_packet_busy) begin
                // Probe abandoned: keep the chosen antenna through a packet
                if (div_state != SRAC_DIV_WAIT) begin
                    antenna <= rssi_ant1 > rssi_ant0;
                end
                div_state <= SRAC_DIV_WAIT;
                div_timer <= ant_cfg[31:16];
            end else begin
                case (div_state)
                    SRAC_DIV_WAIT: begin
                        if (div_timer != 16'h0000) begin
                            div_timer <= div_timer - 16'h0001;
                        end else begin
                            antenna <= 1'b0;
                            div_timer <= {8'h00, ant_cfg[15:8]};
                            div_state <= SRAC_DIV_DWELL_0;
                        end
                    end
                    SRAC_DIV_DWELL_0: begin
                        if (div_timer != 16'h0000) begin
                            div_timer <= div_timer - 16'h0001;
                        end else begin
                            rssi_ant0 <= rssi;
                            antenna <= 1'b1;
                            div_timer <= {8'h00, ant_cfg[15:8]};
                            div_state <= SRAC_DIV_DWELL_1;
                        end
                    end
                    SRAC_DIV_DWELL_1: begin
                        if (div_timer != 16'h0000) begin
                            div_timer <= div_timer - 16'h0001;
                        end else begin
                            rssi_ant1 <= rssi;
                            div_state <= SRAC_DIV_PICK;
                        end
                    end
                    SRAC_DIV_PICK: begin
                        antenna <= rssi_ant1 > rssi_ant0;
                        div_timer <= ant_cfg[31:16];
                        if (ant_cfg[`SRAC_ANT_LOG_BIT]) begin
                            rssi_fifo_wr <= 1'b1;
                            rssi_fifo_data <= {2'h0, rssi_ant0};
                            div_state <= SRAC_DIV_LOG;
                        end else begin
                            div_state <= SRAC_DIV_WAIT;
                        end
                    end
                    SRAC_DIV_LOG: begin
                        rssi_fifo_wr <= 1'b1;
                        rssi_fifo_data <= {2'h1, rssi_ant1};
                        div_state <= SRAC_DIV_WAIT;
                    end
                    default: begin
                        div_state <= SRAC_DIV_WAIT;
                    end
                endcase
            end
        end
    end

    // Antenna pins and switching
    always_ff @(posedge clk) begin
        if (rst) begin
            internal_switch_tx <= 1'b0;
            single_ended_tx_pin_en <= 1'b0;
            txrx_switch_pin_o <= 1'b0;
            txrx_switch_pin_oe <= 1'b0;
            antenna_select_pin_o <= 1'b0;
            antenna_select_pin_oe <= 1'b0;
        end else begin
            internal_switch_tx <= ant_cfg[`SRAC_ANT_DIFF_BIT] && tx_active;
            single_ended_tx_pin_en <= !ant_cfg[`SRAC_ANT_DIFF_BIT] && tx_active;
            txrx_switch_pin_o <= tx_active;
            txrx_switch_pin_oe <= radio_alt_function_reg[`SRAC_ALT_SWITCH_BIT]
                && port_b_direction[`SRAC_DIR_SWITCH_BIT];
            antenna_select_pin_o <= antenna;
            antenna_select_pin_oe <= radio_alt_function_reg[`SRAC_ALT_ANTSEL_BIT]
                && port_b_direction[`SRAC_DIR_ANTSEL_BIT];
        end
    end

    // Read path
    always_comb begin
        rd_ok = 1'b1;
        case (axi_req.araddr)
            `SRAC_OFS_FREQ_A: rd_word = freq_a;
            `SRAC_OFS_FREQ_B: rd_word = freq_b;
            `SRAC_OFS_RANGING_A: rd_word = {26'h0, ranging_fault, go_a, rng_range};
            `SRAC_OFS_RANGING_B: rd_word = {26'h0, ranging_fault, go_b, rng_range};
            `SRAC_OFS_LOOP: rd_word = {30'h0, loop_norm};
            `SRAC_OFS_LOOP_BOOST: rd_word = {30'h0, loop_boost};
            `SRAC_OFS_PUMP: rd_word = {24'h0, pump_norm};
            `SRAC_OFS_PUMP_BOOST: rd_word = {24'h0, pump_boost};
            `SRAC_OFS_VCO_DIV: rd_word = {26'h0, vco_div};
            `SRAC_OFS_BOOST_CFG: rd_word = {15'h0, boost_cfg[16:0]};
            `SRAC_OFS_ANT_CFG: rd_word = ant_cfg;
            `SRAC_OFS_ALT_FUNC: rd_word = {24'h0, radio_alt_function_reg};
            `SRAC_OFS_DIR_B: rd_word = {24'h0, port_b_direction};
            `SRAC_OFS_STATUS: rd_word = {rssi_ant1, rssi_ant0, 12'h0, antenna,
                                         boost_active, rng_busy, vco_high};
            default: begin
                rd_word = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            axi_rsp.arready <= 1'b1;
            axi_rsp.rvalid <= 1'b0;
            axi_rsp.rdata <= 32'h0000_0000;
            axi_rsp.rresp <= `SRAC_RESP_OKAY;
        end else if (axi_req.arvalid && axi_rsp.arready) begin
            axi_rsp.arready <= 1'b0;
            axi_rsp.rvalid <= 1'b1;
            axi_rsp.rdata <= rd_word;
            axi_rsp.rresp <= rd_ok ? `SRAC_RESP_OKAY : `SRAC_RESP_SLVERR;
        end else if (axi_rsp.rvalid && axi_req.rready) begin
            axi_rsp.rvalid <= 1'b0;
            axi_rsp.arready <= 1'b1;
        end
    end

endmodule

//--- verification/srac_asserts.sv
`timescale 1ns/1ps
module srac_asserts
    import srac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stimulus side
    input wire srac_axi_req_s axi_req,
    input wire srac_axi_rsp_s axi_rsp,
    input wire logic synth_on,
    input wire logic tx_active,
    // Watched outputs
    input wire logic boost_active,
    input wire logic internal_switch_tx,
    input wire logic single_ended_tx_pin_en,
    input wire logic txrx_switch_pin_o,
    input wire logic rssi_fifo_wr,
    input wire logic [9:0] rssi_fifo_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_log0;
        rssi_fifo_wr && rssi_fifo_data[9:8] == 2'h0;
    endsequence
    property p_wr_ans; s_wr_take |-> ##[1:2] axi_rsp.bvalid; endproperty
    property p_rd_ans; axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid; endproperty
    property p_b_hold; axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid; endproperty
    property p_boost_off; $fell(synth_on) |-> ##[1:2] !boost_active; endproperty
    property p_mode_excl; !(internal_switch_tx && single_ended_tx_pin_en); endproperty
    property p_int_sw; internal_switch_tx || single_ended_tx_pin_en |-> $past(tx_active); endproperty
    property p_sw_o; txrx_switch_pin_o == $past(tx_active); endproperty
    property p_fifo_pair;
        s_log0 |=> rssi_fifo_wr && rssi_fifo_data[9:8] == 2'h1 ##1 !rssi_fifo_wr;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    a_boost_off: assert property (p_boost_off) else $error("boost kept after stop");
    a_mode_excl: assert property (p_mode_excl) else $error("both antenna modes");
    a_int_sw: assert property (p_int_sw) else $error("tx path without tx");
    a_sw_o: assert property (p_sw_o) else $error("switch pin value");
    a_fifo_pair: assert property (p_fifo_pair) else $error("rssi pair broken");
endmodule

bind srac_top srac_asserts u_chk (.clk, .rst, .axi_req, .axi_rsp, .synth_on, .tx_active,
    .boost_active, .internal_switch_tx, .single_ended_tx_pin_en, .txrx_switch_pin_o,
    .rssi_fifo_wr, .rssi_fifo_data);

//--- verification/tb_srac_top.sv
`timescale 1ns/1ps
module tb_srac_top
    import srac_pkg::*;
;
    `define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
        $display("[ERR] %0t got %h exp %h", $time, g, e); end end
    logic clk = 1'b0;
    logic rst = 1'b1;
    srac_axi_req_s req = '0;
    srac_axi_rsp_s rsp;
    logic synth_on = 1'b0, tx_active = 1'b0, vco_hi = 1'b0;
    logic [7:0] rssi = 8'h20;
    logic [3:0] vr;
    srac_loop_s loop;
    logic vpin, bact, isw, sepin, sw_o, sw_oe, odiv, osel, isel, asel_o, asel_oe, fwr;
    logic [9:0] fdat;
    logic [19:0] flog = '0;
    logic [1:0] refd, rc;
    logic [31:0] rd, sfreq;
    int errors = 0, checked = 0, n;
    always #12.5 clk = ~clk;
    // Comparator stand-in: VCO reads high from range 9 up
    always @(posedge clk) vco_hi <= (vr >= 4'h9);
    // RSSI stand-in: antenna one is the stronger
    always @(posedge clk) rssi <= asel_o ? 8'h40 : 8'h20;
    always @(posedge clk) if (fwr) flog <= {flog[9:0], fdat};
    srac_top uut (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .synth_on(synth_on),
        .tx_active(tx_active), .rx_packet_busy(1'b0), .rssi(rssi), .vco_high_async(vco_hi),
        .synth_freq(sfreq), .vco_range(vr), .loop_active(loop), .loop_voltage_pin_en(vpin),
        .ref_divider_field(refd), .output_divider_bit(odiv), .osc_source_sel(osel),
        .inductor_sel(isel), .boost_active(bact), .internal_switch_tx(isw),
        .single_ended_tx_pin_en(sepin), .txrx_switch_pin_o(sw_o), .txrx_switch_pin_oe(sw_oe),
        .antenna_select_pin_o(asel_o), .antenna_select_pin_oe(asel_oe), .rssi_fifo_wr(fwr),
        .rssi_fifo_data(fdat));
    task automatic print_verdict;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        rc = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rd = rsp.rdata;
        rc = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic rng(input logic [7:0] a);
        wr(a, 32'h10);
        n = 0;
        do begin
            rdr(a);
            n++;
        end while (rd[4] && n < 20000);
    endtask
    initial begin
        #1500000;
        errors++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdr(8'h10);
        `CHK(rd, 32'h1);
        `CHK(loop, {2'h1, 8'h10});
        wr(8'h00, 32'h1234_5678);
        wr(8'h04, 32'h0ABC_DEF1);
        rdr(8'h00);
        `CHK(rd, 32'h1234_5678);
        rdr(8'h3C);
        `CHK(rc, 2'h2);
        wr(8'h20, 32'h37);
        repeat (3) @(posedge clk);
        `CHK({refd, odiv, osel, isel}, 5'h1F);
        wr(8'h20, 32'h10);
        rng(8'h08);
        `CHK(rd[5:4], 2'h2);
        wr(8'h20, 32'h30);
        rng(8'h0C);
        `CHK(rd[5:4], 2'h0);
        `CHK(n > 100, 1'b1);
        repeat (3) @(posedge clk);
        `CHK(sfreq, 32'h0ABC_DEF1);
        `CHK({rd[3:0], vr}, 8'h88);
        wr(8'h14, 32'h3);
        wr(8'h1C, 32'h80);
        wr(8'h24, 32'h1_0010);
        synth_on <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK({bact, loop}, {1'b1, 2'h3, 8'h80});
        synth_on <= 1'b0;
        repeat (2) @(posedge clk);
        synth_on <= 1'b1;
        repeat (14) @(posedge clk);
        `CHK(loop, {2'h3, 8'h80});
        repeat (25) @(posedge clk);
        `CHK(loop, {2'h1, 8'h10});
        synth_on <= 1'b0;
        wr(8'h10, 32'h0);
        repeat (3) @(posedge clk);
        `CHK(vpin, 1'b1);
        tx_active <= 1'b1;
        wr(8'h2C, 32'hC0);
        wr(8'h30, 32'hC);
        repeat (3) @(posedge clk);
        `CHK({sw_oe, sw_o, isw, sepin}, 4'hE);
        wr(8'h28, 32'h0004_0406);
        wr(8'h30, 32'h8);
        repeat (3) @(posedge clk);
        `CHK({sw_oe, isw, sepin}, 3'h1);
        repeat (200) @(posedge clk);
        wr(8'h28, 32'h0);
        repeat (3) @(posedge clk);
        `CHK({asel_oe, asel_o}, 2'h3);
        `CHK(flog, {10'h020, 10'h140});
        rdr(8'h34);
        `CHK(rd[31:16], 16'h4020);
        print_verdict;
    end
endmodule
